// [logic/path_error_perf_counters.sv]
// per-channel path error, far-end error and code violation performance counters
//
// Overview of operation
// - 12-bit BIP-2 count at 0x26 and 0x27
// - path mode adds one per BIP-2 error
// - hierarchy mode adds one per errored block
// - writing zero clears BIP and REI counts
// - BIP overflow sets status, event, perf flags
// - per-second tick latches BIP count, restarts it
// - 12-bit REI count at 0x28 and 0x29
// - REI overflow sets status, event, perf flags
// - per-second tick latches REI count, restarts it
// - read-only code violation shadow at 0x2a, 0x2b
// - one-second timing from external input pin
// - block check select in byte-sync mode latches CRC-6 count instead
// - code violation counter, optional excessive zeros
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
`include "path_error_perf_counters_defs.svh"

module path_error_perf_counters
(
    input  wire logic                            clk,                   // 125 MHz clock
    input  wire logic                            rst_b,                 // async reset, low
    input  wire path_error_perf_counters_pkg::byte_t addr,              // register address
    input  wire path_error_perf_counters_pkg::byte_t wr_data,           // register write data
    input  wire logic                            wr_en,                 // write strobe
    input  wire logic                            rd_en,                 // read strobe
    output wire path_error_perf_counters_pkg::byte_t rd_data,           // read data, next cycle
    output logic                                 irq,                   // level interrupt
    input  wire logic                            bip_check_valid,       // one block checked
    input  wire path_error_perf_counters_pkg::inc_t bip_error_bits,     // errored BIP-2 bits
    input  wire logic                            far_block_error,       // one REI received
    input  wire logic                            code_violation,        // line code violation
    input  wire logic                            excess_zero,           // excessive zeros seen
    input  wire logic                            block_check_error,     // CRC-6 error
    input  wire logic                            byte_sync_mode,        // byte-synchronous map
    input  wire logic                            one_second_tick_input, // one-second pin
    output wire path_error_perf_counters_pkg::count_t latched_bip_error_count,      // shadow
    output wire path_error_perf_counters_pkg::count_t latched_far_block_error_count // shadow
);
    import path_error_perf_counters_pkg::*;

    // register state
    byte_t  control_r;
    byte_t  irq_mask_r;
    flags_t irq_status_r;
    count_t bip_error_count_r;
    count_t far_block_error_count_r;
    count_t code_violation_count_r;
    count_t latched_code_violation_count_r;
    count_t latched_bip_r;
    count_t latched_far_r;
    byte_t  rd_data_r;
    logic   irq_r;

    // next values
    count_t bip_error_count_nxt;
    count_t far_block_error_count_nxt;
    count_t code_violation_count_nxt;
    flags_t irq_status_nxt;

    // one-second pin synchroniser and edge detector
    logic   tick_meta_r;
    logic   tick_sync_r;
    logic   tick_prev_r;
    wire    tick_rise;

    // control fields
    wire    hierarchy_mode_select;
    wire    per_second_monitor_enable;
    wire    excess_zero_count_enable;
    wire    block_check_count_select;
    wire    use_block_check;

    // address decode
    wire    sel_control;
    wire    sel_bip_low;
    wire    sel_bip_high;
    wire    sel_far_low;
    wire    sel_far_high;
    wire    sel_lcv_low;
    wire    sel_lcv_high;
    wire    sel_irq_status;
    wire    sel_irq_mask;

    // count arithmetic
    inc_t   bip_inc;
    inc_t   far_inc;
    inc_t   cv_inc;
    sum_t   bip_sum;
    sum_t   far_sum;
    sum_t   cv_sum;
    wire    bip_write;
    wire    far_write;
    wire    bip_low_wr;
    wire    bip_high_wr;
    wire    far_low_wr;
    wire    far_high_wr;
    wire    irq_pending;
    wire    bip_overflow;
    wire    far_overflow;
    wire    interval_restart;
    flags_t flag_set;
    flags_t flag_clear;
    byte_t  rd_mux;

    // control fields out of the control register
    assign hierarchy_mode_select     = control_r[`CTL_HIERARCHY_BIT];
    assign per_second_monitor_enable = control_r[`CTL_PER_SECOND_BIT];
    assign excess_zero_count_enable  = control_r[`CTL_EXCESS_ZERO_BIT];
    assign block_check_count_select  = control_r[`CTL_BLOCK_CHECK_BIT];
    assign use_block_check = block_check_count_select & byte_sync_mode;

    // address decode of the register port
    assign sel_control    = (addr == `OFS_CONTROL);
    assign sel_bip_low    = (addr == `OFS_BIP_LOW);
    assign sel_bip_high   = (addr == `OFS_BIP_HIGH);
    assign sel_far_low    = (addr == `OFS_FAR_LOW);
    assign sel_far_high   = (addr == `OFS_FAR_HIGH);
    assign sel_lcv_low    = (addr == `OFS_LCV_LOW);
    assign sel_lcv_high   = (addr == `OFS_LCV_HIGH);
    assign sel_irq_status = (addr == `OFS_IRQ_STATUS);
    assign sel_irq_mask   = (addr == `OFS_IRQ_MASK);

    // software writes to either byte of a count take priority over counting
    assign bip_write = wr_en & (sel_bip_low | sel_bip_high);
    assign far_write = wr_en & (sel_far_low | sel_far_high);

    // per-byte write strobes of the two counts
    assign bip_low_wr  = wr_en & sel_bip_low;
    assign bip_high_wr = wr_en & sel_bip_high;
    assign far_low_wr  = wr_en & sel_far_low;
    assign far_high_wr = wr_en & sel_far_high;

    // a rising edge of the synchronised pin marks the end of a second
    assign tick_rise        = tick_sync_r & ~tick_prev_r;
    assign interval_restart = tick_rise & per_second_monitor_enable;

    // BIP-2 increment: each errored bit, or one per errored block
    always_comb
    begin
        bip_inc = 2'h0;
        if (bip_check_valid)
        begin
            if (hierarchy_mode_select)
                bip_inc = {1'b0, |bip_error_bits};
            else
                bip_inc = bip_error_bits;
        end
    end

    // far-end block errors count one each
    assign far_inc = {1'b0, far_block_error};

    // code violation source: CRC-6 errors, or violations plus excessive zeros
    always_comb
    begin
        cv_inc = 2'h0;
        if (use_block_check)
            cv_inc = {1'b0, block_check_error};
        else
            cv_inc = {1'b0, code_violation} + {1'b0, excess_zero & excess_zero_count_enable};
    end

    // sums with carry; the carry marks a wrap through zero
    assign bip_sum = {1'b0, bip_error_count_r} + {11'h000, bip_inc};
    assign far_sum = {1'b0, far_block_error_count_r} + {11'h000, far_inc};
    assign cv_sum  = {1'b0, code_violation_count_r} + {11'h000, cv_inc};

    // overflow only counts when the count really advances
    assign bip_overflow = bip_sum[12] & ~bip_write & ~interval_restart;
    assign far_overflow = far_sum[12] & ~far_write & ~interval_restart;

    // BIP-2 count next value: write, interval restart, or free count
    always_comb
    begin
        bip_error_count_nxt = bip_sum[11:0];
        if (bip_low_wr)
            bip_error_count_nxt = {bip_error_count_r[11:8], wr_data};
        else if (bip_high_wr)
            bip_error_count_nxt = {wr_data[3:0], bip_error_count_r[7:0]};
        else if (interval_restart)
            bip_error_count_nxt = {10'h000, bip_inc};
    end

    // REI count next value: write, interval restart, or free count
    always_comb
    begin
        far_block_error_count_nxt = far_sum[11:0];
        if (far_low_wr)
            far_block_error_count_nxt = {far_block_error_count_r[11:8], wr_data};
        else if (far_high_wr)
            far_block_error_count_nxt = {wr_data[3:0], far_block_error_count_r[7:0]};
        else if (interval_restart)
            far_block_error_count_nxt = {10'h000, far_inc};
    end

    // code violation source count restarts each second when monitoring
    always_comb
    begin
        code_violation_count_nxt = cv_sum[11:0];
        if (interval_restart)
            code_violation_count_nxt = {10'h000, cv_inc};
    end

    // which overflow flags an overflow sets this cycle
    assign flag_set[`FLG_BIP_STATUS]      = bip_overflow;
    assign flag_set[`FLG_BIP_EVENT]       = bip_overflow;
    assign flag_set[`FLG_BIP_PERF_STATUS] = bip_overflow & per_second_monitor_enable;
    assign flag_set[`FLG_BIP_PERF_EVENT]  = bip_overflow & per_second_monitor_enable;
    assign flag_set[`FLG_FAR_STATUS]      = far_overflow;
    assign flag_set[`FLG_FAR_EVENT]       = far_overflow;
    assign flag_set[`FLG_FAR_PERF_STATUS] = far_overflow & per_second_monitor_enable;
    assign flag_set[`FLG_FAR_PERF_EVENT]  = far_overflow & per_second_monitor_enable;

    // write one to clear the overflow flags
    assign flag_clear = (wr_en && sel_irq_status) ? wr_data : 8'h00;

    // interrupt request from the flags about to be stored
    assign irq_pending = |(irq_status_nxt & irq_mask_r);

    // sticky flags: a set in the clearing cycle wins
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_flag
            always_comb
            begin
                irq_status_nxt[i] = flag_set[i] | (irq_status_r[i] & ~flag_clear[i]);
            end
        end
    endgenerate

    // read data selection, reserved bits read as zero
    always_comb
    begin
        rd_mux = 8'h00;
        if (sel_control)
            rd_mux = control_r;
        else if (sel_bip_low)
            rd_mux = bip_error_count_r[7:0];
        else if (sel_bip_high)
            rd_mux = {4'h0, bip_error_count_r[11:8]};
        else if (sel_far_low)
            rd_mux = far_block_error_count_r[7:0];
        else if (sel_far_high)
            rd_mux = {4'h0, far_block_error_count_r[11:8]};
        else if (sel_lcv_low)
            rd_mux = latched_code_violation_count_r[7:0];
        else if (sel_lcv_high)
            rd_mux = {4'h0, latched_code_violation_count_r[11:8]};
        else if (sel_irq_status)
            rd_mux = irq_status_r;
        else if (sel_irq_mask)
            rd_mux = irq_mask_r;
    end

    // two-flop synchroniser on the one-second pin, then an edge register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tick_meta_r <= 1'b0;
            tick_sync_r <= 1'b0;
            tick_prev_r <= 1'b0;
        end
        else
        begin
            tick_meta_r <= one_second_tick_input;
            tick_sync_r <= tick_meta_r;
            tick_prev_r <= tick_sync_r;
        end
    end

    // control register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            control_r <= `RST_CONTROL;
        else if (wr_en && sel_control)
            control_r <= wr_data;
    end

    // interrupt mask register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_mask_r <= `RST_MASK;
        else if (wr_en && sel_irq_mask)
            irq_mask_r <= wr_data;
    end

    // overflow flags
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_status_r <= `RST_FLAGS;
        else
            irq_status_r <= irq_status_nxt;
    end

    // the two path error counts
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bip_error_count_r       <= `RST_COUNT;
            far_block_error_count_r <= `RST_COUNT;
        end
        else
        begin
            bip_error_count_r       <= bip_error_count_nxt;
            far_block_error_count_r <= far_block_error_count_nxt;
        end
    end

    // code violation source count
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            code_violation_count_r <= `RST_COUNT;
        else
            code_violation_count_r <= code_violation_count_nxt;
    end

    // code violation shadow loads every second, monitoring or not
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            latched_code_violation_count_r <= `RST_COUNT;
        else if (tick_rise)
            latched_code_violation_count_r <= code_violation_count_r;
    end

    // path error shadows load at the second when monitoring
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            latched_bip_r <= `RST_COUNT;
            latched_far_r <= `RST_COUNT;
        end
        else if (interval_restart)
        begin
            latched_bip_r <= bip_error_count_r;
            latched_far_r <= far_block_error_count_r;
        end
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rd_data_r <= `RST_BYTE;
        else if (rd_en)
            rd_data_r <= rd_mux;
        else
            rd_data_r <= 8'h00;
    end

    // interrupt registered on the same edge as the flags it follows
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_r <= 1'b0;
        else
            irq_r <= irq_pending;
    end

    // outputs straight from flip-flops
    assign rd_data                       = rd_data_r;
    assign irq                           = irq_r;
    assign latched_bip_error_count       = latched_bip_r;
    assign latched_far_block_error_count = latched_far_r;

endmodule

// [logic/path_error_perf_counters_defs.svh]
// register offsets, field positions and reset values of the path error counters
`ifndef PATH_ERROR_PERF_COUNTERS_DEFS_SVH
`define PATH_ERROR_PERF_COUNTERS_DEFS_SVH

// register offsets (byte addresses on the 8-bit register port)
`define OFS_CONTROL        8'h01
`define OFS_BIP_LOW        8'h26
`define OFS_BIP_HIGH       8'h27
`define OFS_FAR_LOW        8'h28
`define OFS_FAR_HIGH       8'h29
`define OFS_LCV_LOW        8'h2a
`define OFS_LCV_HIGH       8'h2b
`define OFS_IRQ_STATUS     8'h3a
`define OFS_IRQ_MASK       8'h3b

// control register fields
`define CTL_HIERARCHY_BIT  0
`define CTL_PER_SECOND_BIT 1
`define CTL_EXCESS_ZERO_BIT 2
`define CTL_BLOCK_CHECK_BIT 4

// interrupt status / mask fields
`define FLG_BIP_STATUS      0
`define FLG_BIP_EVENT       1
`define FLG_BIP_PERF_STATUS 2
`define FLG_BIP_PERF_EVENT  3
`define FLG_FAR_STATUS      4
`define FLG_FAR_EVENT       5
`define FLG_FAR_PERF_STATUS 6
`define FLG_FAR_PERF_EVENT  7

// reset values
`define RST_CONTROL        8'h00
`define RST_MASK           8'h00
`define RST_FLAGS          8'h00
`define RST_COUNT          12'h000
`define RST_BYTE           8'h00

`endif

// [logic/path_error_perf_counters_pkg.sv]
// types shared by the path error performance counters
package path_error_perf_counters_pkg;
    typedef logic [7:0]  byte_t;   // register port data and address
    typedef logic [11:0] count_t;  // one 12-bit error count
    typedef logic [12:0] sum_t;    // count plus carry out
    typedef logic [1:0]  inc_t;    // increment of one cycle, 0 to 2
    typedef logic [7:0]  flags_t;  // overflow flag vector
endpackage

// [verif/path_error_perf_counters_properties.sv]
// assertion checker for the path error performance counters
`timescale 1ns/10ps
module path_error_perf_counters_chk
(
    input wire logic                                 clk,                  // clock
    input wire logic                                 rst_b,                // reset, low
    input wire path_error_perf_counters_pkg::byte_t  addr,                 // address
    input wire path_error_perf_counters_pkg::byte_t  wr_data,              // write data
    input wire logic                                 wr_en,                // write strobe
    input wire logic                                 rd_en,                // read strobe
    input wire path_error_perf_counters_pkg::byte_t  rd_data,              // read data
    input wire logic                                 irq,                  // interrupt
    input wire logic                                 bip_check_valid,      // bip event
    input wire logic                                 far_block_error,      // far event
    input wire logic                                 one_second_tick_input, // second pin
    input wire path_error_perf_counters_pkg::count_t latched_bip_error_count,      // shadow
    input wire path_error_perf_counters_pkg::count_t latched_far_block_error_count // shadow
);
    import path_error_perf_counters_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // read port behaviour
    a_high_res_zero: assert property (rd_en && addr inside {8'h27, 8'h29, 8'h2b}
        |=> rd_data[7:4] == 4'h0) else $error("reserved count bits not zero");
    a_rd_idle_zero: assert property (!rd_en |=> rd_data == 8'h00)
        else $error("read data without a read");
    // a zero write followed by a quiet read returns zero
    a_bip_clear: assert property ((wr_en && addr == 8'h26 && wr_data == 8'h00
        && !bip_check_valid) ##1 (!wr_en && !bip_check_valid) ##1 (rd_en && addr == 8'h26
        && !bip_check_valid) |=> rd_data == 8'h00) else $error("bip count not cleared");
    a_far_clear: assert property ((wr_en && addr == 8'h28 && wr_data == 8'h00
        && !far_block_error) ##1 (!wr_en && !far_block_error) ##1 (rd_en && addr == 8'h28
        && !far_block_error) |=> rd_data == 8'h00) else $error("far count not cleared");
    // shadows move only three edges after the second pin rises
    a_bip_shadow_tick: assert property ($changed(latched_bip_error_count)
        |-> $past(one_second_tick_input, 3) && !$past(one_second_tick_input, 4))
        else $error("bip shadow moved off tick");
    a_far_shadow_tick: assert property ($changed(latched_far_block_error_count)
        |-> $past(one_second_tick_input, 3) && !$past(one_second_tick_input, 4))
        else $error("far shadow moved off tick");
    // a flag clear drops the interrupt at once, a mask write one edge later
    a_irq_fall_cause: assert property ($fell(irq)
        |-> ($past(wr_en) && $past(addr) == 8'h3a) || ($past(wr_en, 2) && $past(addr, 2) == 8'h3b))
        else $error("interrupt dropped without software");
    a_irq_rise_cause: assert property ($rose(irq)
        |-> $past(bip_check_valid || far_block_error) || $past(wr_en, 2))
        else $error("interrupt raised without cause");

    // main scenarios
    c_irq_rise: cover property ($rose(irq));
    c_irq_fall: cover property ($fell(irq));
    c_shadow_load: cover property ($changed(latched_bip_error_count));
endmodule

bind path_error_perf_counters path_error_perf_counters_chk chk_u (
    .clk                           (clk),
    .rst_b                         (rst_b),
    .addr                          (addr),
    .wr_data                       (wr_data),
    .wr_en                         (wr_en),
    .rd_en                         (rd_en),
    .rd_data                       (rd_data),
    .irq                           (irq),
    .bip_check_valid               (bip_check_valid),
    .far_block_error               (far_block_error),
    .one_second_tick_input         (one_second_tick_input),
    .latched_bip_error_count       (latched_bip_error_count),
    .latched_far_block_error_count (latched_far_block_error_count)
);

// [verif/test_path_error_perf_counters.sv]
// self-checking bench for the path error performance counters
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module test_path_error_perf_counters;
    import path_error_perf_counters_pkg::*;
    logic   clk, rst_b, wr_en, rd_en, bip_check_valid, far_block_error, code_violation, irq;
    logic   excess_zero, block_check_error, byte_sync_mode, one_second_tick_input;
    byte_t  addr, wr_data, rd_data, d, ctl;
    inc_t   bip_error_bits;
    count_t latched_bip_error_count, latched_far_block_error_count, eb, ef, ec;
    int     mismatches, checks;
    byte_t  offs[10] = '{8'h01, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h3a, 8'h3b, 8'h40};

    path_error_perf_counters dut_u (.clk, .rst_b, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
        .irq, .bip_check_valid, .bip_error_bits, .far_block_error, .code_violation,
        .excess_zero, .block_check_error, .byte_sync_mode, .one_second_tick_input,
        .latched_bip_error_count, .latched_far_block_error_count);

    // clock generator
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // expected increments of one event cycle
    function automatic count_t bip_inc(input logic v, input inc_t b);
        return !v ? 12'h000 : ctl[0] ? count_t'(b != 2'h0) : count_t'(b);
    endfunction
    function automatic count_t cv_inc(input logic cv, input logic ez, input logic ce);
        if (ctl[4] && byte_sync_mode)
            return count_t'(ce);
        return count_t'(cv) + count_t'(ez && ctl[2]);
    endfunction

    // register port cycles
    task automatic wr(input byte_t a, input byte_t v);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= v;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input byte_t a, output byte_t v);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask
    task automatic wctl(input byte_t v);
        ctl = v;
        wr(8'h01, v);
    endtask
    task automatic chkc(input string n, input byte_t lo, input count_t e);
        rd(lo, d);
        `CHK(n, e[7:0], d)
        rd(lo + 8'h01, d);
        `CHK(n, {4'h0, e[11:8]}, d)
    endtask
    task automatic clr(input byte_t lo);
        wr(lo + 8'h01, 8'h00);
        wr(lo, 8'h00);
        rd(lo, d);
        `CHK("cleared", 8'h00, d)
    endtask
    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    // random events for n cycles, summed into the expected counts
    task automatic run(input int n);
        logic v, f, cv, ez, ce;
        inc_t b;
        repeat (n)
        begin
            @(posedge clk);
            v = 1'($urandom);
            f = 1'($urandom);
            cv = 1'($urandom);
            ez = 1'($urandom);
            ce = 1'($urandom);
            b = inc_t'($urandom % 3);
            bip_check_valid <= v;
            bip_error_bits <= b;
            far_block_error <= f;
            code_violation <= cv;
            excess_zero <= ez;
            block_check_error <= ce;
            eb += bip_inc(v, b);
            ef += count_t'(f);
            ec += cv_inc(cv, ez, ce);
        end
        @(posedge clk);
        {bip_check_valid, far_block_error, code_violation, excess_zero, block_check_error} <= 0;
    endtask
    task automatic tick;
        @(posedge clk);
        one_second_tick_input <= 1'b1;
        repeat (4) @(posedge clk);
        one_second_tick_input <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_sim;
    end

    // main sequence
    initial
    begin
        {rst_b, wr_en, rd_en, bip_check_valid, far_block_error, code_violation} = 0;
        {excess_zero, block_check_error, byte_sync_mode, one_second_tick_input} = 0;
        {addr, wr_data, bip_error_bits, ctl} = 0;
        void'($urandom(32'h56ad));
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        foreach (offs[i])
        begin
            rd(offs[i], d);
            `CHK("reset value", 8'h00, d)
        end
        wctl(8'he0);
        rd(8'h01, d);
        `CHK("control", 8'he0, d)
        wr(8'h2a, 8'h5a);
        rd(8'h2a, d);
        `CHK("shadow read only", 8'h00, d)
        $display("test registers done");
        for (int h = 0; h < 2; h++)
        begin
            wctl(8'(h));
            clr(8'h26);
            clr(8'h28);
            eb = 0;
            ef = 0;
            run(60);
            chkc("bip count", 8'h26, eb);
            chkc("far count", 8'h28, ef);
        end
        $display("test counting done");
        for (int p = 0; p < 2; p++)
        begin
            wctl(8'(p << 1));
            wr(8'h3b, 8'hff);
            wr(8'h26, 8'hff);
            wr(8'h27, 8'h0f);
            wr(8'h28, 8'hff);
            wr(8'h29, 8'h0f);
            @(posedge clk);
            bip_check_valid <= 1'b1;
            bip_error_bits <= 2'h1;
            far_block_error <= 1'b1;
            @(posedge clk);
            bip_check_valid <= 1'b0;
            far_block_error <= 1'b0;
            chkc("bip wrap", 8'h26, 12'h000);
            chkc("far wrap", 8'h28, 12'h000);
            rd(8'h3a, d);
            `CHK("flags", p ? 8'hff : 8'h33, d)
            `CHK("irq on", 1'b1, irq)
            wr(8'h3b, 8'h00);
            settle;
            `CHK("irq masked", 1'b0, irq)
            wr(8'h3b, 8'hff);
            settle;
            `CHK("irq held", 1'b1, irq)
            wr(8'h3a, 8'hff);
            settle;
            `CHK("irq cleared", 1'b0, irq)
        end
        $display("test overflow done");
        for (int m = 0; m < 3; m++)
        begin
            wctl(m == 0 ? 8'h06 : 8'h16);
            byte_sync_mode <= (m != 2);
            tick;
            {eb, ef, ec} = 0;
            run(60);
            tick;
            `CHK("bip shadow", eb, latched_bip_error_count)
            `CHK("far shadow", ef, latched_far_block_error_count)
            chkc("violation shadow", 8'h2a, ec);
            chkc("bip restart", 8'h26, 12'h000);
            chkc("far restart", 8'h28, 12'h000);
        end
        $display("test one second done");
        end_sim;
    end
endmodule
